// *** rtl/pmc_top.sv ***
// Purpose: pin-mode decode, calibration trigger, power-down and 1:2 output demux
// Assumes: input clock and all pins are asynchronous to clk_in and are synchronised
// Notes: the input clock must be well below half of clk_in (bench: 400 ns vs 50 ns)
`timescale 1ns/1ps

// How it works
// - 80 low then 80 high cycles start calibration
// - mid-level range pin selects extended control mode
// - range pin low 650 mV, high 870 mV
// - extended mode: swing pin is serial clock
// - swing pin high normal, low reduced amplitude
// - edge pin picks output clock data edge
// - mid-level edge pin enables double data rate
// - extended mode: edge pin is serial data
// - resync pulse resets the output clock
// - power-down held while request pin high
// - wait pin picks power-up calibration delay
// - extended mode: wait pin is select, delay short
// - samples captured on input clock falling edge
// - samples alternate across two output buses
// - output words are offset binary
// - each output word is eight bits
module pmc_top
  import pmc_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic sample_clock_in,
  input wire logic [PMC_SAMPLE_W-1:0] conv_code_in,
  input wire logic range_above_in,
  input wire logic range_below_in,
  input wire logic edge_above_in,
  input wire logic edge_below_in,
  input wire logic output_swing_select_in,
  input wire logic calibration_wait_select_in,
  input wire logic calibration_trigger_in,
  input wire logic powerdown_request_in,
  input wire logic output_clock_resync_in,
  output logic extended_mode_out,
  output logic range_wide_out,
  output logic swing_normal_out,
  output logic ddr_mode_out,
  output logic serial_clock_out,
  output logic serial_data_in_out,
  output logic serial_select_out,
  output logic cal_wait_long_out,
  output logic calibrating_out,
  output logic powerdown_out,
  output logic output_clock_true_out,
  output logic [PMC_SAMPLE_W-1:0] bus_a_out,
  output logic [PMC_SAMPLE_W-1:0] bus_b_out
);

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = PMC_SAMPLE_W + 11;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] sync_raw;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 19'h00140; // below bits set: pins read low, no mid

  assign sync_raw = {conv_code_in, sample_clock_in, range_above_in, range_below_in,
    edge_above_in, edge_below_in, output_swing_select_in, calibration_wait_select_in,
    calibration_trigger_in, powerdown_request_in, output_clock_resync_in, 1'b0};

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sync1 <= SYNC_RESET;
      sync2 <= SYNC_RESET;
    end
    else
    begin
      sync1 <= sync_raw;
      sync2 <= sync1;
    end
  end

  logic [PMC_SAMPLE_W-1:0] code_s;
  logic sclk_s, rng_hi_s, rng_lo_s, edg_hi_s, edg_lo_s, swing_s, wait_s, trig_s, pd_s, rsy_s;
  assign {code_s, sclk_s, rng_hi_s, rng_lo_s, edg_hi_s, edg_lo_s, swing_s, wait_s,
    trig_s, pd_s, rsy_s} = sync2[SYNC_W-1:1];

  // ----------------------------------------------------------------
  // edge detection on synchronised levels
  // ----------------------------------------------------------------
  logic sclk_d;
  logic rsy_d;
  logic samp_fall;
  logic rsy_rise;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sclk_d <= 1'b0;
      rsy_d <= 1'b0;
    end
    else
    begin
      sclk_d <= sclk_s;
      rsy_d <= rsy_s;
    end
  end

  assign samp_fall = sclk_d & ~sclk_s;
  assign rsy_rise = rsy_s & ~rsy_d;

  // ----------------------------------------------------------------
  // three-level decode
  // ----------------------------------------------------------------
  function automatic pmc_level_e pmc_decode(input logic above, input logic below);
    if (above)
      return PMC_LVL_HIGH;
    else if (below)
      return PMC_LVL_LOW;
    else
      return PMC_LVL_MID;
  endfunction : pmc_decode

  pmc_level_e range_lvl;
  pmc_level_e edge_lvl;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      range_lvl <= PMC_LVL_LOW;
      edge_lvl <= PMC_LVL_LOW;
    end
    else
    begin
      range_lvl <= pmc_decode(rng_hi_s, rng_lo_s);
      edge_lvl <= pmc_decode(edg_hi_s, edg_lo_s);
    end
  end

  // ----------------------------------------------------------------
  // mode outputs
  // ----------------------------------------------------------------
  logic ext;
  assign ext = (range_lvl == PMC_LVL_MID);

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      extended_mode_out <= 1'b0;
      range_wide_out <= 1'b0;
      swing_normal_out <= 1'b0;
      ddr_mode_out <= 1'b0;
      serial_clock_out <= 1'b0;
      serial_data_in_out <= 1'b0;
      serial_select_out <= 1'b0;
      cal_wait_long_out <= 1'b0;
      powerdown_out <= 1'b0;
    end
    else
    begin
      extended_mode_out <= ext;
      range_wide_out <= !ext && range_lvl == PMC_LVL_HIGH;
      swing_normal_out <= !ext && swing_s;
      serial_clock_out <= ext && swing_s;
      ddr_mode_out <= !ext && edge_lvl == PMC_LVL_MID;
      serial_data_in_out <= ext && edge_lvl == PMC_LVL_HIGH;
      serial_select_out <= ext && wait_s;
      cal_wait_long_out <= !ext && wait_s;
      powerdown_out <= pd_s;
    end
  end

  // ----------------------------------------------------------------
  // calibration trigger: low run then high run
  // ----------------------------------------------------------------
  logic [PMC_CNT_W-1:0] trig_low_cnt;
  logic [PMC_CNT_W-1:0] trig_high_cnt;
  logic trig_armed;
  logic cal_trig;

  assign cal_trig = samp_fall && trig_s && trig_armed
    && trig_high_cnt == PMC_CAL_TRIG_CYCLES - 9'h001;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      trig_low_cnt <= PMC_CNT_RESET;
      trig_high_cnt <= PMC_CNT_RESET;
      trig_armed <= 1'b0;
    end
    else if (samp_fall)
    begin
      if (!trig_s)
      begin
        if (trig_low_cnt != PMC_CAL_TRIG_CYCLES)
          trig_low_cnt <= trig_low_cnt + 9'h001;
        trig_high_cnt <= PMC_CNT_RESET;
        trig_armed <= trig_low_cnt >= PMC_CAL_TRIG_CYCLES - 9'h001;
      end
      else
      begin
        trig_low_cnt <= PMC_CNT_RESET;
        if (cal_trig)
          trig_armed <= 1'b0;
        else if (trig_armed)
          trig_high_cnt <= trig_high_cnt + 9'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // calibration sequencer
  // ----------------------------------------------------------------
  pmc_cal_e cal_state;
  logic [PMC_CNT_W-1:0] cal_cnt;
  logic [PMC_CNT_W-1:0] wait_limit;

  assign wait_limit = cal_wait_long_out ? PMC_WAIT_LONG : PMC_WAIT_SHORT;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cal_state <= PMC_CAL_WAIT;
      cal_cnt <= PMC_CNT_RESET;
    end
    else if (pd_s)
    begin
      cal_state <= PMC_CAL_WAIT;
      cal_cnt <= PMC_CNT_RESET;
    end
    else if (samp_fall)
    begin
      case (cal_state)
        PMC_CAL_WAIT:
        begin
          cal_cnt <= cal_cnt + 9'h001;
          if (cal_cnt + 9'h001 >= wait_limit)
          begin
            cal_state <= PMC_CAL_RUNNING;
            cal_cnt <= PMC_CNT_RESET;
          end
        end
        PMC_CAL_IDLE:
        begin
          if (cal_trig)
            cal_state <= PMC_CAL_RUNNING;
          cal_cnt <= PMC_CNT_RESET;
        end
        PMC_CAL_RUNNING:
        begin
          cal_cnt <= cal_cnt + 9'h001;
          if (cal_cnt == PMC_CAL_RUN - 9'h001)
            cal_state <= PMC_CAL_IDLE;
        end
        default:
          cal_state <= PMC_CAL_WAIT;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      calibrating_out <= 1'b0;
    else
      calibrating_out <= !pd_s && (cal_state == PMC_CAL_RUNNING
        || (cal_state == PMC_CAL_IDLE && cal_trig));
  end

  // ----------------------------------------------------------------
  // sample capture, 1:2 demux, output clock
  // ----------------------------------------------------------------
  logic phase;
  logic [PMC_SAMPLE_W-1:0] hold_a;
  logic [PMC_SAMPLE_W-1:0] offset_code;
  logic edge_rise;

  assign offset_code = {~code_s[PMC_SAMPLE_W-1], code_s[PMC_SAMPLE_W-2:0]};
  assign edge_rise = (edge_lvl == PMC_LVL_HIGH);

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      phase <= 1'b0;
      hold_a <= PMC_BUS_RESET;
      bus_a_out <= PMC_BUS_RESET;
      bus_b_out <= PMC_BUS_RESET;
      output_clock_true_out <= 1'b0;
    end
    else if (rsy_rise)
    begin
      phase <= 1'b0;
      output_clock_true_out <= 1'b0;
    end
    else if (samp_fall && !pd_s && !calibrating_out)
    begin
      phase <= ~phase;
      if (!phase)
      begin
        hold_a <= offset_code;
        if (!ddr_mode_out)
          output_clock_true_out <= ~edge_rise;
      end
      else
      begin
        bus_a_out <= hold_a;
        bus_b_out <= offset_code;
        if (ddr_mode_out)
          output_clock_true_out <= ~output_clock_true_out;
        else
          output_clock_true_out <= edge_rise;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  chk_trigger_starts_cal: assert property (
    cal_trig && !pd_s |=> calibrating_out ##1 calibrating_out)
    else $error("calibration did not start after trigger");
  chk_ext_mode_decode: assert property (
    range_lvl == PMC_LVL_MID |=> extended_mode_out && !range_wide_out)
    else $error("mid-level range pin did not select extended mode");
  chk_range_wide: assert property (
    range_lvl == PMC_LVL_HIGH |=> range_wide_out && !extended_mode_out)
    else $error("high range pin did not select wide range");
  chk_serial_clock: assert property (
    ext && swing_s |=> serial_clock_out && !swing_normal_out)
    else $error("serial clock not routed in extended mode");
  chk_swing_normal: assert property (
    !ext |=> swing_normal_out == $past(swing_s) && !serial_clock_out)
    else $error("swing select wrong outside extended mode");
  chk_ddr_select: assert property (
    !ext && edge_lvl == PMC_LVL_MID |=> ddr_mode_out)
    else $error("mid-level edge pin did not enable double rate");
  chk_serial_data: assert property (
    ext |=> !ddr_mode_out && serial_data_in_out == ($past(edge_lvl) == PMC_LVL_HIGH))
    else $error("serial data not taken from edge pin");
  chk_powerdown_hold: assert property (
    pd_s ##1 pd_s |-> powerdown_out && !calibrating_out)
    else $error("power-down not held");
  chk_wait_forced_short: assert property (
    extended_mode_out |-> !cal_wait_long_out)
    else $error("calibration wait not forced short in extended mode");
  chk_resync_clock: assert property (
    rsy_rise |=> !output_clock_true_out && !phase)
    else $error("resync did not reset the output clock");
  chk_demux_pair: assert property (
    samp_fall && phase && !pd_s && !calibrating_out && !rsy_rise
    |=> bus_a_out == $past(hold_a) && bus_b_out == $past(offset_code))
    else $error("demux pair not presented");
  chk_offset_binary: assert property (
    samp_fall && !phase && !pd_s && !calibrating_out && !rsy_rise
    |=> hold_a[PMC_SAMPLE_W-1] == ~$past(code_s[PMC_SAMPLE_W-1]))
    else $error("sample not in offset binary");
  chk_sdr_edge: assert property (
    samp_fall && phase && !ddr_mode_out && !pd_s && !calibrating_out && !rsy_rise
    |=> output_clock_true_out == $past(edge_rise))
    else $error("output clock edge does not match edge select");

  cov_cal_trigger: cover property (cal_trig);
  cov_ddr_pair: cover property (ddr_mode_out && samp_fall && phase);
  cov_resync: cover property (rsy_rise);
  cov_ext_mode: cover property (extended_mode_out && serial_select_out);

endmodule : pmc_top

// *** rtl/pmc_pkg.sv ***
// Purpose: shared constants and types for the converter pin-mode and output control block
// Assumes: every count is in input (sample) clock cycles unless named otherwise
// Notes: three-level pins are seen through two comparator outputs (above-high, below-low)
package pmc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PMC_SAMPLE_W = 8;
  localparam int PMC_CNT_W = 9;

  // ----------------------------------------------------------------
  // calibration timing, in input clock cycles
  // ----------------------------------------------------------------
  localparam logic [PMC_CNT_W-1:0] PMC_CAL_TRIG_CYCLES = 9'h050;
  localparam logic [PMC_CNT_W-1:0] PMC_WAIT_SHORT = 9'h010;
  localparam logic [PMC_CNT_W-1:0] PMC_WAIT_LONG = 9'h100;
  localparam logic [PMC_CNT_W-1:0] PMC_CAL_RUN = 9'h040;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [PMC_SAMPLE_W-1:0] PMC_BUS_RESET = 8'h00;
  localparam logic [PMC_CNT_W-1:0] PMC_CNT_RESET = 9'h000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PMC_LVL_LOW, PMC_LVL_HIGH, PMC_LVL_MID} pmc_level_e;
  typedef enum logic [1:0] {PMC_CAL_WAIT, PMC_CAL_IDLE, PMC_CAL_RUNNING} pmc_cal_e;

endpackage : pmc_pkg

// *** tb/pmc_host_model.sv ***
// Purpose: host side of the converter pins: input clock, core codes, trigger
// Assumes: input clock runs free at 400 ns
// Notes: codes are valid only around the falling edge, inverse elsewhere
`timescale 1ns/1ps
module pmc_host_model
  import pmc_pkg::*;
(
  input wire logic [1:0] code_hi_in,
  output logic sample_clock_out,
  output logic [PMC_SAMPLE_W-1:0] conv_code_out,
  output logic calibration_trigger_out
);
  logic [5:0] count;

  initial
  begin
    count = 6'h00;
    sample_clock_out = 1'b1;
    conv_code_out = 8'h00;
    calibration_trigger_out = 1'b1;
    #37;
    forever
    begin
      #100;
      conv_code_out = {code_hi_in, count};
      #100;
      sample_clock_out = 1'b0;
      #100;
      conv_code_out = ~conv_code_out;
      #100;
      sample_clock_out = 1'b1;
      count = count + 6'h01;
    end
  end

  // low run, high run, then a one-cycle low blip back to idle high
  task cal_seq(input int lo, input int hi);
    @(posedge sample_clock_out);
    calibration_trigger_out = 1'b0;
    repeat (lo) @(negedge sample_clock_out);
    @(posedge sample_clock_out);
    calibration_trigger_out = 1'b1;
    repeat (hi) @(negedge sample_clock_out);
    @(posedge sample_clock_out);
    calibration_trigger_out = 1'b0;
    @(posedge sample_clock_out);
    calibration_trigger_out = 1'b1;
  endtask : cal_seq
endmodule : pmc_host_model

// *** tb/tb.sv ***
// Purpose: self-checking bench for pmc_top
// Assumes: host model makes the input clock and codes
// Notes: waits are in clk_in cycles of 50 ns, one sample is 8 cycles
`timescale 1ns/1ps
module tb;
  logic clk_in, nrst, ra, rb, ea, eb, sw, wt, pd, rs, sclk, trig;
  logic ext, wide, swn, ddr, sck, sdi, ssel, lng, cal, pdo, oclk;
  logic [1:0] ch;
  logic [7:0] code, bus_a, bus_b, frz;
  int err_total, total_checks;
  // pins {ra, rb, ea, eb, sw, wt} beside expected mode outputs
  logic [13:0] rows [7] = '{14'h1a20, 14'h2541, 14'h2270, 14'h0b8e, 14'h0480, 14'h0288,
                           14'h3d41};

  pmc_host_model host (.code_hi_in(ch), .sample_clock_out(sclk), .conv_code_out(code),
    .calibration_trigger_out(trig));
  pmc_top dut (.clk_in(clk_in), .nrst_in(nrst), .sample_clock_in(sclk), .conv_code_in(code),
    .range_above_in(ra), .range_below_in(rb), .edge_above_in(ea), .edge_below_in(eb),
    .output_swing_select_in(sw), .calibration_wait_select_in(wt),
    .calibration_trigger_in(trig), .powerdown_request_in(pd), .output_clock_resync_in(rs),
    .extended_mode_out(ext), .range_wide_out(wide), .swing_normal_out(swn),
    .ddr_mode_out(ddr), .serial_clock_out(sck), .serial_data_in_out(sdi),
    .serial_select_out(ssel), .cal_wait_long_out(lng), .calibrating_out(cal),
    .powerdown_out(pdo), .output_clock_true_out(oclk), .bus_a_out(bus_a), .bus_b_out(bus_b));

  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // ----
  // helpers
  // ----
  task tally_and_finish();
    if (err_total == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task tick(input int k);
    repeat (k) @(posedge clk_in);
    #2;
  endtask : tick

  task wait_cal(input logic v, input int lim, output int n);
    n = 0;
    while (cal !== v)
    begin
      tick(1);
      n++;
      if (n > lim)
      begin
        chk("calibration wait bound", 8'h00, 8'h01);
        tally_and_finish();
      end
    end
  endtask : wait_cal

  task cal_run(input int w);
    int n;
    wait_cal(1'b1, w + 40, n);
    chk("calibration wait", 8'h01, (n > w - 24) && (n < w + 24));
    wait_cal(1'b0, 600, n);
    chk("calibration length", 8'h01, (n > 488) && (n < 536));
  endtask : cal_run

  task pwrup(input logic [5:0] p, input int w);
    nrst = 1'b0;
    {ra, rb, ea, eb, sw, wt} = p;
    tick(5);
    chk("reset flags", 8'h00, {cal, pdo, oclk, ext});
    chk("reset buses", 8'h00, bus_a | bus_b);
    nrst = 1'b1;
    cal_run(w);
  endtask : pwrup

  // m: 0 sdr falling, 1 sdr rising, 2 double rate
  task pair(input logic [1:0] m);
    logic [7:0] a0;
    logic pc;
    int n;
    a0 = bus_a;
    n = 0;
    while (bus_a === a0)
    begin
      pc = oclk;
      tick(1);
      n++;
      if (n > 40)
      begin
        chk("pair bound", 8'h00, 8'h01);
        tally_and_finish();
      end
    end
    chk("bus_a format", ch ^ 2'b10, bus_a[7:6]);
    chk("bus_b format", ch ^ 2'b10, bus_b[7:6]);
    chk("pair order", {bus_a[5:0] + 6'h01}, bus_b[5:0]);
    if (m == 2'd2)
      chk("ddr clock", pc ^ 1'b1, oclk);
    else
      chk("sdr clock", m[0], oclk);
  endtask : pair

  // ----
  // sequence
  // ----
  initial
  begin
    err_total = 0;
    total_checks = 0;
    nrst = 1'b0;
    pd = 1'b0;
    rs = 1'b0;
    ch = 2'b00;
    {ra, rb, ea, eb, sw, wt} = 6'h2a;
    pwrup(6'h2a, 128);
    for (int i = 0; i < 7; i++)
    begin
      {ra, rb, ea, eb, sw, wt} = rows[i][13:8];
      tick(6);
      chk("mode outputs", rows[i][7:0], {ext, wide, swn, ddr, sck, sdi, ssel, lng});
    end
    {ra, rb, ea, eb, sw, wt} = 6'h2a;
    tick(24);
    pair(2'd1);
    pair(2'd1);
    ch = 2'b11;
    {ra, rb, ea, eb, sw, wt} = 6'h26;
    tick(24);
    pair(2'd0);
    {ra, rb, ea, eb, sw, wt} = 6'h22;
    tick(24);
    pair(2'd2);
    pair(2'd2);
    {ra, rb, ea, eb, sw, wt} = 6'h2a;
    tick(24);
    // resync just after a pair update, while the output clock is high
    pair(2'd1);
    rs = 1'b1;
    tick(2);
    rs = 1'b0;
    tick(2);
    chk("clock after resync", 8'h00, oclk);
    pair(2'd1);
    // short runs on either side must not start calibration
    host.cal_seq(80, 79);
    tick(10);
    chk("short high run", 8'h00, cal);
    host.cal_seq(79, 80);
    tick(10);
    chk("short low run", 8'h00, cal);
    host.cal_seq(80, 80);
    tick(1);
    chk("trigger start", 8'h01, cal);
    cal_run(0);
    pd = 1'b1;
    tick(4);
    chk("power-down", 8'h01, pdo);
    frz = bus_a;
    tick(40);
    chk("power-down held", 8'h01, pdo);
    chk("bus frozen", frz, bus_a);
    pd = 1'b0;
    cal_run(128);
    pwrup(6'h2b, 2048);
    pwrup(6'h0b, 128);
    tally_and_finish();
  end
endmodule : tb
